// file: rtl/status_monitor_pkg.sv
// constants, carriers and helpers of the safety status flag monitor
package status_monitor_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] FLAGS_OFS = 8'h00;
  localparam logic [7:0] OUT_MASK_OFS = 8'h04;
  localparam logic [7:0] EVENT_OFS = 8'h08;
  localparam logic [7:0] EVENT_MASK_OFS = 8'h0C;
  localparam logic [7:0] SOURCE_OFS = 8'h10;
  localparam logic [7:0] CLOCK_FAULT_OFS = 8'h14;

  // reset values
  localparam logic [31:0] FLAGS_RST = 32'h00000000;
  localparam logic [31:0] OUT_MASK_RST = 32'h00000000;
  localparam logic [31:0] EVENT_RST = 32'h00000000;
  localparam logic [31:0] EVENT_MASK_RST = 32'h00000000;
  localparam logic [31:0] CLOCK_FAULT_RST = 32'h00000000;

  // bits that exist in the flag word; 23 and 31 are hard zero
  localparam logic [31:0] FLAGS_IMPL = 32'h7F7FFFFF;

  // field positions of the flag word
  localparam int POS_LOOP_X = 0;
  localparam int POS_LOOP_V = 4;
  localparam int POS_LOOP_ID = 8;
  localparam int POS_LOOP_IQ = 12;
  localparam int POS_VOLT = 16;
  localparam int POS_PLL = 19;
  localparam int POS_PINS_SW = 20;
  localparam int POS_PWM_MIN = 24;
  localparam int POS_PWM_MAX = 25;
  localparam int POS_ADC_I = 26;
  localparam int POS_ADC_ENC = 27;
  localparam int POS_PINS_IDX = 28;

  // clock fault register fields
  localparam int POS_CF_FLAG = 0;
  localparam int POS_CF_MASK = 8;
  localparam logic [31:0] CLOCK_FAULT_IMPL = 32'h00000101;

  localparam int SYNC_W = 6;

  // one control loop: bit 0 target .. bit 3 output
  typedef struct packed {
    logic output_clip;
    logic errsum_clip;
    logic rate_clip;
    logic target_clip;
  } loop_limit_t;

  typedef struct packed {
    logic magnitude;
    logic quadrature;
    logic direct;
  } volt_clip_t;

  // pin level inputs, bit 0 right switch .. bit 5 analog encoder index
  typedef struct packed {
    logic analog_encoder_index;
    logic second_encoder_index;
    logic first_encoder_index;
    logic home_switch_left;
    logic home_switch_home;
    logic home_switch_right;
  } pin_inputs_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // rate clipping counts only while that loop's rate limiter is enabled
  function automatic logic [3:0] loop_bits(input loop_limit_t l,
                                           input logic rate_en);
    loop_bits = {l.output_clip, l.errsum_clip, l.rate_clip & rate_en,
                 l.target_clip};
  endfunction

endpackage

// file: rtl/flag_sync.sv
// two-stage synchroniser bank for asynchronous pin levels
module flag_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule

// file: rtl/safety_status_flag_monitor.sv
// safety status flag register, output-select mask and interrupt logic
module safety_status_flag_monitor (
  input wire logic clock,
  input wire logic arst_n,
  input wire status_monitor_pkg::reg_req_t reg_req,
  output logic [31:0] read_data,
  input wire status_monitor_pkg::loop_limit_t position_loop,
  input wire status_monitor_pkg::loop_limit_t velocity_loop,
  input wire status_monitor_pkg::loop_limit_t flux_loop,
  input wire status_monitor_pkg::loop_limit_t torque_loop,
  input wire logic [3:0] rate_limit_enable,
  input wire status_monitor_pkg::volt_clip_t voltage_clip,
  input wire logic pwm_duty_min,
  input wire logic pwm_duty_max,
  input wire logic adc_current_clip,
  input wire logic adc_encoder_clip,
  input wire logic pll_unlocked,
  input wire logic clock_watchdog_fault,
  input wire status_monitor_pkg::pin_inputs_t pins,
  output logic status_out,
  output logic irq
);

  // synchronised pin levels
  status_monitor_pkg::pin_inputs_t pins_sync;

  flag_sync #(
    .W(status_monitor_pkg::SYNC_W)
  ) u_pin_sync (
    .clock(clock),
    .arst_n(arst_n),
    .async_in(pins),
    .sync_out(pins_sync)
  );


  // live source word

  logic [31:0] source;

  always_comb begin
    source = 32'h00000000;
    source[status_monitor_pkg::POS_LOOP_X +: 4] =
      status_monitor_pkg::loop_bits(position_loop,
                                    rate_limit_enable[0]);
    source[status_monitor_pkg::POS_LOOP_V +: 4] =
      status_monitor_pkg::loop_bits(velocity_loop,
                                    rate_limit_enable[1]);
    source[status_monitor_pkg::POS_LOOP_ID +: 4] =
      status_monitor_pkg::loop_bits(flux_loop,
                                    rate_limit_enable[2]);
    source[status_monitor_pkg::POS_LOOP_IQ +: 4] =
      status_monitor_pkg::loop_bits(torque_loop,
                                    rate_limit_enable[3]);
    source[status_monitor_pkg::POS_VOLT +: 3] = voltage_clip;
    source[status_monitor_pkg::POS_PLL] = pll_unlocked;
    source[status_monitor_pkg::POS_PINS_SW +: 3] =
      {pins_sync.home_switch_left, pins_sync.home_switch_home,
       pins_sync.home_switch_right};
    source[status_monitor_pkg::POS_PWM_MIN] = pwm_duty_min;
    source[status_monitor_pkg::POS_PWM_MAX] = pwm_duty_max;
    source[status_monitor_pkg::POS_ADC_I] = adc_current_clip;
    source[status_monitor_pkg::POS_ADC_ENC] = adc_encoder_clip;
    source[status_monitor_pkg::POS_PINS_IDX +: 3] =
      {pins_sync.analog_encoder_index, pins_sync.second_encoder_index,
       pins_sync.first_encoder_index};
    source = source & status_monitor_pkg::FLAGS_IMPL;
  end


  // register strobes

  logic wr_flags;
  logic wr_out_mask;
  logic wr_event;
  logic wr_event_mask;
  logic wr_clock_fault;

  always_comb begin
    wr_flags = reg_req.wr &
      status_monitor_pkg::hit(reg_req.addr, status_monitor_pkg::FLAGS_OFS);
    wr_out_mask = reg_req.wr &
      status_monitor_pkg::hit(reg_req.addr, status_monitor_pkg::OUT_MASK_OFS);
    wr_event = reg_req.wr &
      status_monitor_pkg::hit(reg_req.addr, status_monitor_pkg::EVENT_OFS);
    wr_event_mask = reg_req.wr &
      status_monitor_pkg::hit(reg_req.addr,
                              status_monitor_pkg::EVENT_MASK_OFS);
    wr_clock_fault = reg_req.wr &
      status_monitor_pkg::hit(reg_req.addr,
                              status_monitor_pkg::CLOCK_FAULT_OFS);
  end


  // flag register: whole-word write, active sources always win

  logic [31:0] flags_q;
  logic [31:0] flags_d;

  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = reg_req.wdata;
    end
    flags_d = (flags_d | source) & status_monitor_pkg::FLAGS_IMPL;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= status_monitor_pkg::FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end


  // output-select mask

  logic [31:0] out_mask_q;
  logic [31:0] out_mask_d;

  always_comb begin
    out_mask_d = out_mask_q;
    if (wr_out_mask) begin
      out_mask_d = reg_req.wdata & status_monitor_pkg::FLAGS_IMPL;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_mask_q <= status_monitor_pkg::OUT_MASK_RST;
    end else begin
      out_mask_q <= out_mask_d;
    end
  end


  // clock watchdog flag and its pin enable

  logic [31:0] clock_fault_q;
  logic [31:0] clock_fault_d;

  always_comb begin
    clock_fault_d = clock_fault_q;
    if (wr_clock_fault) begin
      clock_fault_d = reg_req.wdata;
    end
    clock_fault_d[status_monitor_pkg::POS_CF_FLAG] =
      clock_fault_d[status_monitor_pkg::POS_CF_FLAG] |
      clock_watchdog_fault;
    clock_fault_d = clock_fault_d & status_monitor_pkg::CLOCK_FAULT_IMPL;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clock_fault_q <= status_monitor_pkg::CLOCK_FAULT_RST;
    end else begin
      clock_fault_q <= clock_fault_d;
    end
  end


  // event capture: rising edge of each source, sticky, write one to clear

  logic [31:0] source_q;
  logic [31:0] event_q;
  logic [31:0] event_d;
  logic [31:0] event_mask_q;
  logic [31:0] event_mask_d;
  logic [31:0] rise;

  always_comb begin
    rise = source & ~source_q;
    event_d = event_q;
    if (wr_event) begin
      event_d = event_d & ~reg_req.wdata;
    end
    // a new edge in the clearing cycle survives
    event_d = (event_d | rise) & status_monitor_pkg::FLAGS_IMPL;
    event_mask_d = event_mask_q;
    if (wr_event_mask) begin
      event_mask_d = reg_req.wdata & status_monitor_pkg::FLAGS_IMPL;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      source_q <= 32'h00000000;
      event_q <= status_monitor_pkg::EVENT_RST;
      event_mask_q <= status_monitor_pkg::EVENT_MASK_RST;
    end else begin
      source_q <= source;
      event_q <= event_d;
      event_mask_q <= event_mask_d;
    end
  end


  // status pin and interrupt line, from next-state values

  logic status_d;
  logic irq_d;

  always_comb begin
    status_d = (|(flags_d & out_mask_d)) |
      (clock_fault_d[status_monitor_pkg::POS_CF_FLAG] &
       clock_fault_d[status_monitor_pkg::POS_CF_MASK]);
    irq_d = |(event_d & event_mask_d);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      status_out <= status_d;
      irq <= irq_d;
    end
  end


  // read port: data in the cycle after the strobe, zero otherwise

  logic [31:0] read_d;

  always_comb begin
    read_d = 32'h00000000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        status_monitor_pkg::FLAGS_OFS: begin
          read_d = flags_q;
        end
        status_monitor_pkg::OUT_MASK_OFS: begin
          read_d = out_mask_q;
        end
        status_monitor_pkg::EVENT_OFS: begin
          read_d = event_q;
        end
        status_monitor_pkg::EVENT_MASK_OFS: begin
          read_d = event_mask_q;
        end
        status_monitor_pkg::SOURCE_OFS: begin
          read_d = source_q;
        end
        status_monitor_pkg::CLOCK_FAULT_OFS: begin
          read_d = clock_fault_q;
        end
        default: begin
          read_d = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      read_data <= 32'h00000000;
    end else begin
      read_data <= read_d;
    end
  end

endmodule

// file: testbench/safety_status_flag_monitor_props.sv
// assertion checker for the safety status flag monitor
module safety_status_flag_monitor_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire status_monitor_pkg::reg_req_t reg_req,
  input wire logic [31:0] read_data,
  input wire status_monitor_pkg::loop_limit_t position_loop,
  input wire status_monitor_pkg::loop_limit_t velocity_loop,
  input wire status_monitor_pkg::loop_limit_t flux_loop,
  input wire status_monitor_pkg::loop_limit_t torque_loop,
  input wire logic [3:0] rate_limit_enable,
  input wire status_monitor_pkg::volt_clip_t voltage_clip,
  input wire logic pwm_duty_min,
  input wire logic pwm_duty_max,
  input wire logic adc_current_clip,
  input wire logic adc_encoder_clip,
  input wire logic pll_unlocked,
  input wire logic clock_watchdog_fault,
  input wire status_monitor_pkg::pin_inputs_t pins,
  input wire logic status_out,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [31:0] src, src_q, hold, mask_q, emask_q;
  logic [5:0] p1, p2, p3, p4, ph;
  logic cf_q, qt;
  wire rf = reg_req.rd && reg_req.addr == status_monitor_pkg::FLAGS_OFS;
  wire wf = reg_req.wr && reg_req.addr == status_monitor_pkg::FLAGS_OFS;
  wire wm = reg_req.wr && reg_req.addr == status_monitor_pkg::OUT_MASK_OFS;
  wire we = reg_req.wr && reg_req.addr == status_monitor_pkg::EVENT_MASK_OFS;
  wire wc = reg_req.wr && reg_req.addr == status_monitor_pkg::CLOCK_FAULT_OFS;
  wire rc = reg_req.rd && reg_req.addr == status_monitor_pkg::CLOCK_FAULT_OFS;
  // live source word, rate clipping gated by its enable
  assign src = {4'h0, adc_encoder_clip, adc_current_clip, pwm_duty_max,
    pwm_duty_min, 4'h0, pll_unlocked, voltage_clip,
    torque_loop & {2'h3, rate_limit_enable[3], 1'h1},
    flux_loop & {2'h3, rate_limit_enable[2], 1'h1},
    velocity_loop & {2'h3, rate_limit_enable[1], 1'h1},
    position_loop & {2'h3, rate_limit_enable[0], 1'h1}};
  // pins must be held long enough to cross the synchroniser
  assign ph = pins & p1 & p2 & p3 & p4;
  assign hold = (src & src_q) | {1'h0, ph[5:3], 5'h00, ph[2:0], 20'h00000};
  assign qt = src == 32'h0 && (pins | p1 | p2 | p3) == 6'h00;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {src_q, mask_q, emask_q, cf_q} <= '0;
      {p4, p3, p2, p1} <= '0;
    end else begin
      src_q <= src;
      {p4, p3, p2, p1} <= {p3, p2, p1, pins};
      if (wm) mask_q <= reg_req.wdata;
      if (we) emask_q <= reg_req.wdata;
      if (wc) cf_q <= reg_req.wdata[8];
    end
  end
  a_flags_follow: assert property (
    rf |=> (read_data & $past(hold)) == $past(hold)) else $error("flag lost");
  a_reserved_zero: assert property (
    rf |=> !read_data[31] && !read_data[23]) else $error("reserved bit set");
  a_word_write: assert property (
    (wf && qt) ##1 (rf && qt) |=> read_data ==
    ($past(reg_req.wdata, 2) & status_monitor_pkg::FLAGS_IMPL))
    else $error("flag word write not taken");
  a_mask_quiet: assert property (
    mask_q == 32'h0 && !cf_q && !wm && !wc |=> !status_out)
    else $error("status pin without enabled flag");
  a_mask_drives: assert property (
    mask_q[25] && pwm_duty_max && !wm |=> status_out)
    else $error("enabled flag missed on status pin");
  a_irq_quiet: assert property (
    emask_q == 32'h0 && !we |=> !irq) else $error("irq without mask");
  a_irq_event: assert property (
    emask_q[25] && $rose(pwm_duty_max) && !we |=> irq)
    else $error("irq missed");
  a_watchdog_flag: assert property (
    clock_watchdog_fault ##1 rc |=> read_data[0])
    else $error("watchdog flag missing");
  c_read: cover property (rf ##1 read_data != 32'h0);
  c_status: cover property ($rose(status_out));
  c_irq: cover property ($rose(irq));
endmodule

bind safety_status_flag_monitor safety_status_flag_monitor_props u_props (.*);

// file: testbench/host_status_watch.sv
// host model counting rising edges of status pin and interrupt
module host_status_watch (
  input wire logic clock,
  input wire logic status_out,
  input wire logic irq,
  output int status_rises,
  output int irq_rises
);
  logic s_q = 1'h0;
  logic i_q = 1'h0;
  initial status_rises = 0;
  initial irq_rises = 0;
  always @(posedge clock) begin
    if (status_out === 1'h1 && s_q === 1'h0) status_rises++;
    if (irq === 1'h1 && i_q === 1'h0) irq_rises++;
    s_q <= status_out;
    i_q <= irq;
  end
endmodule

// file: testbench/safety_status_flag_monitor_tb.sv
// self-checking testbench of the safety status flag monitor
module safety_status_flag_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  status_monitor_pkg::reg_req_t reg_req = '0;
  status_monitor_pkg::loop_limit_t position_loop = '0, velocity_loop = '0;
  status_monitor_pkg::loop_limit_t flux_loop = '0, torque_loop = '0;
  status_monitor_pkg::volt_clip_t voltage_clip = '0;
  status_monitor_pkg::pin_inputs_t pins = '0;
  logic [3:0] rate_limit_enable = 4'h0;
  logic pwm_duty_min = 1'h0, pwm_duty_max = 1'h0, pll_unlocked = 1'h0;
  logic adc_current_clip = 1'h0, adc_encoder_clip = 1'h0;
  logic clock_watchdog_fault = 1'h0;
  logic [31:0] read_data;
  logic status_out, irq;
  logic [7:0] fa = status_monitor_pkg::FLAGS_OFS;
  int fail_count = 0, total_checks = 0, status_rises, irq_rises;
  always #4 clock = ~clock;
  safety_status_flag_monitor u_dut (.*);
  host_status_watch u_host (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic w, r, input logic [7:0] a, input [31:0] d);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(1'h1, 1'h0, a, d);
    op(1'h0, 1'h0, 8'h00, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    op(1'h0, 1'h1, a, 32'h0);
    op(1'h0, 1'h0, 8'h00, 32'h0);
    #1 chk(read_data, exp);
  endtask
  task automatic drive(input logic [31:0] w, input logic [3:0] en);
    @(posedge clock);
    position_loop <= w[3:0];
    velocity_loop <= w[7:4];
    flux_loop <= w[11:8];
    torque_loop <= w[15:12];
    voltage_clip <= w[18:16];
    pll_unlocked <= w[19];
    pins <= {w[30:28], w[22:20]};
    pwm_duty_min <= w[24];
    pwm_duty_max <= w[25];
    adc_current_clip <= w[26];
    adc_encoder_clip <= w[27];
    rate_limit_enable <= en;
  endtask
  task automatic t_reset_write;
    for (int a = 0; a < 28; a += 4) rd(8'(a), 32'h0);
    op(1'h1, 1'h0, fa, 32'hFFFFFFFF);
    rd(fa, status_monitor_pkg::FLAGS_IMPL);
    wr(status_monitor_pkg::SOURCE_OFS, 32'hFFFFFFFF);
    rd(status_monitor_pkg::SOURCE_OFS, 32'h0);
    wr(fa, 32'h0);
    rd(fa, 32'h0);
    $display("reset and word write done");
  endtask
  task automatic t_bitmap;
    for (int i = 0; i < 31; i++) begin
      if (status_monitor_pkg::FLAGS_IMPL[i]) begin
        drive(32'h1 << i, 4'hF);
        repeat (4) @(posedge clock);
        drive(32'h0, 4'hF);
        rd(fa, 32'h1 << i);
        wr(fa, 32'h0);
        rd(fa, 32'h0);
      end
    end
    drive(32'h2222, 4'h0);
    drive(32'h0, 4'h0);
    rd(fa, 32'h0);
    $display("flag map done");
  endtask
  task automatic t_pin_irq;
    wr(status_monitor_pkg::OUT_MASK_OFS, 32'h02000000);
    drive(32'h02000000, 4'hF);
    @(posedge clock);
    #1 chk({31'h0, status_out}, 32'h1);
    drive(32'h01000000, 4'hF);
    wr(fa, 32'h0);
    #1 chk({31'h0, status_out}, 32'h0);
    rd(fa, 32'h01000000);
    wr(status_monitor_pkg::OUT_MASK_OFS, 32'h0);
    drive(32'h0, 4'hF);
    wr(status_monitor_pkg::EVENT_OFS, 32'hFFFFFFFF);
    wr(status_monitor_pkg::EVENT_MASK_OFS, 32'h02000000);
    drive(32'h02000000, 4'hF);
    @(posedge clock);
    #1 chk({31'h0, irq}, 32'h1);
    wr(status_monitor_pkg::EVENT_OFS, 32'h02000000);
    #1 chk({31'h0, irq}, 32'h0);
    wr(status_monitor_pkg::EVENT_MASK_OFS, 32'h0);
    drive(32'h0, 4'hF);
    wr(fa, 32'h0);
    $display("status pin and irq done");
  endtask
  task automatic t_watchdog;
    wr(status_monitor_pkg::CLOCK_FAULT_OFS, 32'h100);
    @(posedge clock);
    clock_watchdog_fault <= 1'h1;
    rd(status_monitor_pkg::CLOCK_FAULT_OFS, 32'h101);
    chk({31'h0, status_out}, 32'h1);
    @(posedge clock);
    clock_watchdog_fault <= 1'h0;
    wr(status_monitor_pkg::CLOCK_FAULT_OFS, 32'h100);
    rd(status_monitor_pkg::CLOCK_FAULT_OFS, 32'h100);
    chk({31'h0, status_out}, 32'h0);
    wr(status_monitor_pkg::CLOCK_FAULT_OFS, 32'h0);
    $display("watchdog done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'h1;
    t_reset_write();
    t_bitmap();
    t_pin_irq();
    t_watchdog();
    chk(32'(status_rises), 32'h2);
    chk(32'(irq_rises), 32'h1);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("BAD %0t run limit reached", $time);
    final_report();
  end
endmodule
